//--- mis_pkg.sv
// Package for the instruction execution block: offsets, opcodes, fields, carriers
package mis_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ACC = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PC = 8'h0C;
  localparam logic [7:0] OFF_STACK = 8'h10;
  localparam logic [7:0] OFF_WDOG = 8'h14;
  localparam logic [7:0] OFF_FILE = 8'h18;
  localparam logic [7:0] OFF_FDATA = 8'h1C;

  // ==========================================================================
  // Command word fields
  // ==========================================================================
  localparam int CMD_OP_LSB = 16;
  localparam int CMD_F_LSB = 8;
  localparam int CMD_B_LSB = 4;
  localparam int CMD_D_BIT = 0;
  localparam int CMD_K_LSB = 0;

  // Status bits
  localparam int ST_ZERO = 0;
  localparam int ST_CARRY = 1;
  localparam int ST_POWERDOWN = 2;
  localparam int ST_EXPIRY = 3;
  localparam int ST_IRQ_ALLOW = 4;
  localparam int ST_SLEEP = 5;
  localparam int ST_BUSY = 6;

  // Reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [12:0] PC_RST = 13'h0000;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam int FILE_DEPTH = 128;

  // Two-cycle instructions need one extra cycle
  localparam logic [1:0] TWO_CYCLE_EXTRA = 2'h1;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_AND_IMMEDIATE = 3'h1,
    OP_BIT_FORCE_HIGH = 3'h2,
    OP_INTERRUPT_RETURN = 3'h3,
    OP_RETURN_WITH_LITERAL = 3'h4,
    OP_SUBROUTINE_RETURN = 3'h5,
    OP_ROTATE_LEFT_CARRY = 3'h6,
    OP_ROTATE_RIGHT_CARRY = 3'h7
  } mis_op_t;

  localparam logic [3:0] OP_SLEEP_CODE = 4'h8;

  // Decoded instruction
  typedef struct packed {
    logic [3:0] code;
    logic [6:0] f;
    logic [2:0] b;
    logic d;
    logic [7:0] k;
  } mis_instr_t;

endpackage

//--- mis_rotate.sv
// Rotate-through-carry unit shared by both rotate directions
`timescale 1ns/1ns
`default_nettype none

module mis_rotate (
  input wire logic [7:0] value,
  input wire logic carry_in,
  input wire logic to_left,
  output logic [7:0] result,
  output logic carry_out
);

  // ==========================================================================
  // Rotate
  // ==========================================================================
  always_comb begin
    if (to_left) begin
      result = {value[6:0], carry_in};
      carry_out = value[7];
    end else begin
      result = {carry_in, value[7:1]};
      carry_out = value[0];
    end
  end

endmodule
`default_nettype wire

//--- mis_core.sv
// Instruction execution core with an AHB-Lite register slave
// Contract
// - AND-immediate ANDs accumulator with 8-bit literal, result to accumulator, only zero flag.
// - Bit-force-high sets bit b of file register f, nothing else changes.
// - Rotate-left through carry; d=0 to accumulator, d=1 to f; only carry.
// - Rotate-right through carry; d=0 to accumulator, d=1 to f; only carry.
// - Return-with-literal loads accumulator with literal k and PC from stack head; two cycles; no flags.
// - Subroutine return loads PC from stack head, stack head unchanged; two cycles; no flags.
// - Sleep clears powerdown flag and sets expiry bit; no other flags.
// - Sleep clears watchdog count and prescaler, then enters low-power state.
`timescale 1ns/1ns
`default_nettype none

module mis_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic sleep_req,
  output logic wdog_clear
);

  // ==========================================================================
  // Bus state
  // ==========================================================================
  logic wr_pend_ff, nxt_wr_pend;
  logic [7:0] addr_ff, nxt_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic busy_ff, nxt_busy;
  logic ready_ff, nxt_ready;
  logic sleep_ff, nxt_sleep;
  logic wdclr_ff, nxt_wdclr;

  // Core state
  logic [7:0] acc_ff, nxt_acc;
  logic zero_ff, nxt_zero;
  logic carry_ff, nxt_carry;
  logic pd_ff, nxt_pd;
  logic expiry_ff, nxt_expiry;
  logic irq_allow_ff, nxt_irq_allow;
  logic [12:0] pc_ff, nxt_pc;
  logic [12:0] stack_head_ff, nxt_stack_head;
  logic [7:0] wdog_ff, nxt_wdog;
  logic [7:0] presc_ff, nxt_presc;
  logic [6:0] fsel_ff, nxt_fsel;
  logic [7:0] file_mem [mis_pkg::FILE_DEPTH];
  logic file_we;
  logic [6:0] file_wa;
  logic [7:0] file_wd;

  mis_pkg::mis_instr_t ins;
  logic [7:0] rot_res;
  logic rot_cout;
  logic setup;
  logic [31:0] rd_mux;

  function automatic logic [31:0] status_word(input logic z, input logic c, input logic p,
                                              input logic t, input logic g, input logic s,
                                              input logic b);
    logic [31:0] w;
    w = 32'h00000000;
    w[mis_pkg::ST_ZERO] = z;
    w[mis_pkg::ST_CARRY] = c;
    w[mis_pkg::ST_POWERDOWN] = p;
    w[mis_pkg::ST_EXPIRY] = t;
    w[mis_pkg::ST_IRQ_ALLOW] = g;
    w[mis_pkg::ST_SLEEP] = s;
    w[mis_pkg::ST_BUSY] = b;
    return w;
  endfunction

  assign setup = hsel & hready & htrans[1];
  assign ins.code = hwdata[mis_pkg::CMD_OP_LSB +: 4];
  assign ins.f = hwdata[mis_pkg::CMD_F_LSB +: 7];
  assign ins.b = hwdata[mis_pkg::CMD_B_LSB +: 3];
  assign ins.d = hwdata[mis_pkg::CMD_D_BIT];
  assign ins.k = hwdata[mis_pkg::CMD_K_LSB +: 8];

  mis_rotate u_rot (
    .value(file_mem[ins.f]),
    .carry_in(carry_ff),
    .to_left(ins.code == 4'(mis_pkg::OP_ROTATE_LEFT_CARRY)),
    .result(rot_res),
    .carry_out(rot_cout)
  );

  // ==========================================================================
  // Read mux
  // ==========================================================================
  always_comb begin
    unique case (haddr)
      mis_pkg::OFF_ACC: rd_mux = {24'h000000, acc_ff};
      mis_pkg::OFF_STATUS: rd_mux = status_word(zero_ff, carry_ff, pd_ff, expiry_ff,
                                                irq_allow_ff, sleep_ff, busy_ff);
      mis_pkg::OFF_PC: rd_mux = {19'h00000, pc_ff};
      mis_pkg::OFF_STACK: rd_mux = {19'h00000, stack_head_ff};
      mis_pkg::OFF_WDOG: rd_mux = {16'h0000, presc_ff, wdog_ff};
      mis_pkg::OFF_FILE: rd_mux = {25'h0000000, fsel_ff};
      mis_pkg::OFF_FDATA: rd_mux = {24'h000000, file_mem[fsel_ff]};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_wr_pend = setup & hwrite;
    nxt_addr = setup ? haddr : addr_ff;
    nxt_hrdata = (setup & ~hwrite) ? rd_mux : hrdata_ff;
    nxt_busy = 1'b0;
    nxt_sleep = sleep_ff;
    nxt_wdclr = 1'b0;
    nxt_acc = acc_ff;
    nxt_zero = zero_ff;
    nxt_carry = carry_ff;
    nxt_pd = pd_ff;
    nxt_expiry = expiry_ff;
    nxt_irq_allow = irq_allow_ff;
    nxt_pc = pc_ff;
    nxt_stack_head = stack_head_ff;
    nxt_wdog = wdog_ff + 8'h01;
    nxt_presc = presc_ff + 8'h01;
    nxt_fsel = fsel_ff;
    file_we = 1'b0;
    file_wa = ins.f;
    file_wd = rot_res;
    // Halted oscillator: watchdog held while asleep
    if (sleep_ff) begin
      nxt_wdog = wdog_ff;
      nxt_presc = presc_ff;
    end
    if (wr_pend_ff) begin
      unique case (addr_ff)
        mis_pkg::OFF_CMD: begin
          nxt_sleep = 1'b0;
          nxt_pc = pc_ff + 13'h0001;
          unique case (ins.code)
            4'(mis_pkg::OP_AND_IMMEDIATE): begin
              nxt_acc = acc_ff & ins.k;
              nxt_zero = ((acc_ff & ins.k) == 8'h00);
            end
            4'(mis_pkg::OP_BIT_FORCE_HIGH): begin
              file_we = 1'b1;
              file_wd = file_mem[ins.f] | (8'h01 << ins.b);
            end
            4'(mis_pkg::OP_ROTATE_LEFT_CARRY), 4'(mis_pkg::OP_ROTATE_RIGHT_CARRY): begin
              nxt_carry = rot_cout;
              if (ins.d) begin
                file_we = 1'b1;
              end else begin
                nxt_acc = rot_res;
              end
            end
            4'(mis_pkg::OP_RETURN_WITH_LITERAL): begin
              nxt_acc = ins.k;
              nxt_pc = stack_head_ff;
              nxt_busy = 1'b1;
            end
            4'(mis_pkg::OP_SUBROUTINE_RETURN): begin
              nxt_pc = stack_head_ff;
              nxt_busy = 1'b1;
            end
            4'(mis_pkg::OP_INTERRUPT_RETURN): begin
              nxt_pc = stack_head_ff;
              nxt_irq_allow = 1'b1;
              nxt_busy = 1'b1;
            end
            mis_pkg::OP_SLEEP_CODE: begin
              nxt_pd = 1'b0;
              nxt_expiry = 1'b1;
              nxt_wdog = mis_pkg::WDOG_CLEAR;
              nxt_presc = mis_pkg::WDOG_CLEAR;
              nxt_wdclr = 1'b1;
              nxt_sleep = 1'b1;
            end
            default: nxt_pc = pc_ff + 13'h0001;
          endcase
        end
        mis_pkg::OFF_ACC: nxt_acc = hwdata[7:0];
        mis_pkg::OFF_STATUS: begin
          nxt_zero = hwdata[mis_pkg::ST_ZERO];
          nxt_carry = hwdata[mis_pkg::ST_CARRY];
          nxt_pd = hwdata[mis_pkg::ST_POWERDOWN];
          nxt_expiry = hwdata[mis_pkg::ST_EXPIRY];
          nxt_irq_allow = hwdata[mis_pkg::ST_IRQ_ALLOW];
        end
        mis_pkg::OFF_PC: nxt_pc = hwdata[12:0];
        mis_pkg::OFF_STACK: nxt_stack_head = hwdata[12:0];
        mis_pkg::OFF_FILE: nxt_fsel = hwdata[6:0];
        mis_pkg::OFF_FDATA: begin
          file_we = 1'b1;
          file_wa = fsel_ff;
          file_wd = hwdata[7:0];
        end
        default: nxt_acc = acc_ff;
      endcase
    end
    nxt_ready = ~nxt_busy;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
      busy_ff <= 1'b0;
      ready_ff <= 1'b1;
      sleep_ff <= 1'b0;
      wdclr_ff <= 1'b0;
      acc_ff <= mis_pkg::ACC_RST;
      zero_ff <= 1'b0;
      carry_ff <= 1'b0;
      pd_ff <= 1'b1;
      expiry_ff <= 1'b1;
      irq_allow_ff <= 1'b0;
      pc_ff <= mis_pkg::PC_RST;
      stack_head_ff <= mis_pkg::PC_RST;
      wdog_ff <= mis_pkg::WDOG_CLEAR;
      presc_ff <= mis_pkg::WDOG_CLEAR;
      fsel_ff <= 7'h00;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      addr_ff <= nxt_addr;
      hrdata_ff <= nxt_hrdata;
      busy_ff <= nxt_busy;
      ready_ff <= nxt_ready;
      sleep_ff <= nxt_sleep;
      wdclr_ff <= nxt_wdclr;
      acc_ff <= nxt_acc;
      zero_ff <= nxt_zero;
      carry_ff <= nxt_carry;
      pd_ff <= nxt_pd;
      expiry_ff <= nxt_expiry;
      irq_allow_ff <= nxt_irq_allow;
      pc_ff <= nxt_pc;
      stack_head_ff <= nxt_stack_head;
      wdog_ff <= nxt_wdog;
      presc_ff <= nxt_presc;
      fsel_ff <= nxt_fsel;
    end
  end

  // File memory has no reset; software initialises it
  always_ff @(posedge hclk) begin
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

  // Second cycle of a return stalls the bus, giving the two-cycle timing
  assign hreadyout = ready_ff;
  assign hrdata = hrdata_ff;
  assign hresp = 1'b0;
  assign sleep_req = sleep_ff;
  assign wdog_clear = wdclr_ff;

endmodule
`default_nettype wire

//--- mis_core_properties.sv
// Concurrent checks on the execution core ports
`timescale 1ns/1ns
`default_nettype none
module mis_core_properties (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic sleep_req,
  input wire logic wdog_clear
);
  // ==========================================================================
  // Data phase tracking
  logic dp_ff, nxt_dp, wr_ff, nxt_wr;
  logic [7:0] ad_ff, nxt_ad;
  logic [3:0] op;
  logic cmd_commit, ret_commit, sleep_commit;
  always_comb begin
    nxt_dp = hready ? (hsel && htrans[1]) : dp_ff;
    nxt_wr = hready ? hwrite : wr_ff;
    nxt_ad = hready ? haddr : ad_ff;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_ff <= 1'b0;
      wr_ff <= 1'b0;
      ad_ff <= 8'h00;
    end else begin
      dp_ff <= nxt_dp;
      wr_ff <= nxt_wr;
      ad_ff <= nxt_ad;
    end
  end
  // Commit is the data phase edge, when hwdata carries the command
  assign op = hwdata[mis_pkg::CMD_OP_LSB +: 4];
  assign cmd_commit = dp_ff && wr_ff && (ad_ff == mis_pkg::OFF_CMD) && hready;
  assign ret_commit = cmd_commit && (op inside {4'h3, 4'h4, 4'h5});
  assign sleep_commit = cmd_commit && (op == mis_pkg::OP_SLEEP_CODE);
  // ==========================================================================
  // Properties
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_stall;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_pulse;
    wdog_clear ##1 !wdog_clear;
  endsequence
  property p_ret_stall;
    ret_commit |=> s_stall;
  endproperty
  property p_no_stall;
    cmd_commit && !ret_commit |=> hreadyout;
  endproperty
  property p_stall_cause;
    $fell(hreadyout) |-> $past(ret_commit);
  endproperty
  property p_sleep_pulse;
    sleep_commit |=> s_pulse;
  endproperty
  property p_pulse_cause;
    wdog_clear |-> $past(sleep_commit);
  endproperty
  property p_sleep_level;
    sleep_commit |=> sleep_req;
  endproperty
  property p_sleep_cause;
    $rose(sleep_req) |-> $past(sleep_commit);
  endproperty
  property p_sleep_hold;
    sleep_req && !cmd_commit |=> sleep_req;
  endproperty
  property p_wake;
    sleep_req && cmd_commit && !sleep_commit |=> !sleep_req;
  endproperty
  a_ret_stall: assert property (p_ret_stall) else $error("no stall after return");
  a_no_stall: assert property (p_no_stall) else $error("stall after plain op");
  a_stall_cause: assert property (p_stall_cause) else $error("stall without return");
  a_sleep_pulse: assert property (p_sleep_pulse) else $error("no watchdog clear pulse");
  a_pulse_cause: assert property (p_pulse_cause) else $error("stray watchdog clear");
  a_sleep_level: assert property (p_sleep_level) else $error("no sleep request");
  a_sleep_cause: assert property (p_sleep_cause) else $error("stray sleep request");
  a_sleep_hold: assert property (p_sleep_hold) else $error("sleep request dropped");
  a_wake: assert property (p_wake) else $error("sleep request stuck");
endmodule
bind mis_core mis_core_properties i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .sleep_req(sleep_req), .wdog_clear(wdog_clear));
`default_nettype wire

//--- mis_core_test.sv
// Self-checking bench for the execution core
`timescale 1ns/1ns
`default_nettype none
module mis_core_test;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout, hresp, sleep_req, wdog_clear;
  int errors = 0;
  int checked = 0;
  logic [31:0] ops [3] = '{32'h0004_005A, 32'h0005_0000, 32'h0003_0000};
  logic [31:0] sts [3] = '{32'h0D, 32'h0D, 32'h1D};
  assign hready = hreadyout;
  mis_core i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req),
    .wdog_clear(wdog_clear));
  initial begin
    forever #20 hclk = ~hclk;
  end
  function automatic string reg_name(input logic [7:0] a);
    case (a)
      mis_pkg::OFF_ACC: return "accumulator";
      mis_pkg::OFF_STATUS: return "status";
      mis_pkg::OFF_PC: return "program_counter";
      mis_pkg::OFF_STACK: return "stack_head";
      mis_pkg::OFF_WDOG: return "watchdog_count";
      mis_pkg::OFF_FDATA: return "file_data";
      8'hFF: return "sleep_req";
      8'hFE: return "wdog_clear";
      8'hFD: return "hreadyout";
      8'hFC: return "hresp";
      default: return "register";
    endcase
  endfunction
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", reg_name(a), e, s);
    end
  endtask
  // Single word transfer; waits only on hready, the watchdog bounds it
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(a, e, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(mis_pkg::OFF_STATUS, 32'h0C);
    chk(8'hFC, 32'h0, {31'h0, hresp});
    wr(mis_pkg::OFF_ACC, 32'hF0);
    wr(mis_pkg::OFF_STATUS, 32'h0E);
    wr(mis_pkg::OFF_CMD, 32'h0001_000F);
    rd(mis_pkg::OFF_ACC, 32'h00);
    rd(mis_pkg::OFF_STATUS, 32'h0F);
    wr(mis_pkg::OFF_ACC, 32'hFF);
    wr(mis_pkg::OFF_CMD, 32'h0001_003C);
    rd(mis_pkg::OFF_ACC, 32'h3C);
    rd(mis_pkg::OFF_STATUS, 32'h0E);
    rd(mis_pkg::OFF_PC, 32'h02);
    $display("and test done");
    // Top of the file range, top and bottom bit
    wr(mis_pkg::OFF_FILE, 32'h7F);
    wr(mis_pkg::OFF_FDATA, 32'h00);
    wr(mis_pkg::OFF_CMD, 32'h0002_7F70);
    rd(mis_pkg::OFF_FDATA, 32'h80);
    wr(mis_pkg::OFF_CMD, 32'h0002_7F00);
    rd(mis_pkg::OFF_FDATA, 32'h81);
    rd(mis_pkg::OFF_STATUS, 32'h0E);
    $display("bit set test done");
    wr(mis_pkg::OFF_STATUS, 32'h0D);
    wr(mis_pkg::OFF_CMD, 32'h0007_7F01);
    rd(mis_pkg::OFF_FDATA, 32'h40);
    rd(mis_pkg::OFF_STATUS, 32'h0F);
    wr(mis_pkg::OFF_CMD, 32'h0006_7F00);
    rd(mis_pkg::OFF_ACC, 32'h81);
    rd(mis_pkg::OFF_FDATA, 32'h40);
    rd(mis_pkg::OFF_STATUS, 32'h0D);
    $display("rotate test done");
    wr(mis_pkg::OFF_STACK, 32'h1ABC);
    for (int i = 0; i < 3; i++) begin
      wr(mis_pkg::OFF_PC, 32'h0);
      wr(mis_pkg::OFF_CMD, ops[i]);
      @(posedge hclk);
      chk(8'hFD, 32'h0, {31'h0, hreadyout});
      @(posedge hclk);
      chk(8'hFD, 32'h1, {31'h0, hreadyout});
      rd(mis_pkg::OFF_PC, 32'h1ABC);
      rd(mis_pkg::OFF_STATUS, sts[i]);
    end
    rd(mis_pkg::OFF_ACC, 32'h5A);
    $display("return test done");
    wr(mis_pkg::OFF_STATUS, 32'h07);
    wr(mis_pkg::OFF_CMD, 32'h0008_0000);
    @(posedge hclk);
    chk(8'hFE, 32'h1, {31'h0, wdog_clear});
    @(posedge hclk);
    chk(8'hFE, 32'h0, {31'h0, wdog_clear});
    rd(mis_pkg::OFF_STATUS, 32'h2B);
    rd(mis_pkg::OFF_WDOG, 32'h00);
    rd(mis_pkg::OFF_WDOG, 32'h00);
    chk(8'hFF, 32'h1, {31'h0, sleep_req});
    wr(mis_pkg::OFF_CMD, 32'h0000_0000);
    @(posedge hclk);
    chk(8'hFF, 32'h0, {31'h0, sleep_req});
    $display("sleep test done");
    stop_test();
  end
endmodule
`default_nettype wire
